// >>> rtl/rcg_regs.svh
// Register offsets, field positions and reset values of the reference clock generator
// Operation
// - Enable bit turns whole generator on/off
// - Stop-in-idle halts generator during Idle mode
// - Output enable routes clock onto output pin
// - Run-in-sleep keeps output toggling in Sleep
// - Run-in-sleep ignored for system/bus clock sources
// - Fifteen-bit integer divider sets division ratio
// - Enabled: divider/source wait for switch request
// - Switch bit set by software, hardware clears
// - Request status bit shows active clock request
// - Four-bit source select picks clock source
// - Nine-bit trim in bits 31..23
// - Enabled: trim writes wait for switch request
// - Unimplemented bits ignore writes, read zero
`ifndef RCG_REGS_SVH
`define RCG_REGS_SVH

// ==========================================================
// Register map
`define RCG_CTL_OFS     8'h00
`define RCG_TRIM_OFS    8'h04
`define RCG_CTL_RESET   32'h00000000
`define RCG_TRIM_RESET  32'h00000000

// ==========================================================
// Control register fields
`define RCG_DIV_MSB     30
`define RCG_DIV_LSB     16
`define RCG_ON_BIT      15
`define RCG_STOP_IN_IDLE_BIT    13
`define RCG_OE_BIT      12
`define RCG_RUN_IN_SLEEP_BIT    11
`define RCG_DIVSW_BIT   9
`define RCG_ACTIVE_BIT  8
`define RCG_SEL_MSB     3
`define RCG_SEL_LSB     0
`define RCG_CTL_IMPL    32'h7FFFBB0F

// ==========================================================
// Trim register fields
`define RCG_TRIM_MSB    31
`define RCG_TRIM_LSB    23
`define RCG_TRIM_IMPL   32'hFF800000

`endif

// >>> rtl/rcg_pkg.sv
// Types shared by the reference clock generator files
package rcg_pkg;

  // ==========================================================
  // Source select encodings
  typedef enum logic [3:0] {
    RCG_SRC_SYS    = 4'h0,
    RCG_SRC_PB     = 4'h1,
    RCG_SRC_POSC   = 4'h2,
    RCG_SRC_FRC    = 4'h3,
    RCG_SRC_LOW_POWER_RC_OSC   = 4'h4,
    RCG_SRC_SOSC   = 4'h5,
    RCG_SRC_USBPLL = 4'h6,
    RCG_SRC_SYSPLL = 4'h7,
    RCG_SRC_PIN    = 4'h8
  } rcg_src_e;

  // Divider switch handshake states
  typedef enum logic {
    RCG_SW_IDLE,
    RCG_SW_WAIT
  } rcg_sw_e;

  // Divider configuration travelling together
  typedef struct packed {
    logic [14:0] integer_divider;
    logic [8:0]  fractional_trim;
    logic [3:0]  source_select;
  } rcg_cfg_s;

  typedef logic [1:0] rcg_htrans_t;

endpackage

// >>> rtl/rcg_frac_div.sv
// Fractional divider producing the reference clock from source ticks
`timescale 1ns/1ps
module rcg_frac_div (
  input  wire logic            core_clk_i,
  input  wire logic            srst_i,
  input  wire logic            run_i,
  input  wire logic            tick_i,
  input  wire logic            src_lvl_i,
  input  wire rcg_pkg::rcg_cfg_s cfg_i,
  output logic                 clk_o,
  output logic                 bound_o
);
  import rcg_pkg::*;

  logic [14:0] cnt;
  logic [8:0]  acc;
  logic        extra;
  logic        clk_q;
  logic        div_zero;
  logic        last;
  logic [15:0] half;

  // Half period is divider plus one extra tick on trim carry
  assign div_zero = (cfg_i.integer_divider == 15'h0000);
  assign half     = {1'b0, cfg_i.integer_divider} + {15'h0000, extra};
  assign last     = (({1'b0, cnt} + 16'h0001) == half);

  always_ff @(posedge core_clk_i) begin
    if (srst_i || !run_i) begin
      cnt   <= 15'h0000;
      acc   <= 9'h000;
      extra <= 1'b0;
      clk_q <= 1'b0;
    end else if (tick_i && !div_zero) begin
      if (last) begin
        cnt            <= 15'h0000;
        clk_q          <= ~clk_q;
        {extra, acc}   <= {1'b0, acc} + {1'b0, cfg_i.fractional_trim};
      end else begin
        cnt <= cnt + 15'h0001;
      end
    end
  end

  assign clk_o   = div_zero ? src_lvl_i : clk_q;
  // Safe points for a new setting: stopped or at a half-period edge
  assign bound_o = !run_i || (tick_i && (div_zero || last));

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  AST_HALF_HOLD: assert property (run_i && tick_i && !div_zero && !last |=> $stable(clk_q))
    else $error("divided clock changed before half period ended");
  AST_HALF_TOGGLE: assert property (run_i && tick_i && !div_zero && last |=> clk_q != $past(clk_q))
    else $error("divided clock missed its half period edge");

endmodule

// >>> rtl/rcg_core.sv
// Reference clock generator with AHB-Lite register slave
//
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "rcg_regs.svh"
module rcg_core (
  input  wire logic               core_clk_i,
  input  wire logic               srst_i,
  // AHB-Lite slave
  input  wire logic               hsel_i,
  input  wire logic [31:0]        haddr_i,
  input  wire rcg_pkg::rcg_htrans_t htrans_i,
  input  wire logic               hwrite_i,
  input  wire logic [2:0]         hsize_i,
  input  wire logic [31:0]        hwdata_i,
  input  wire logic               hready_i,
  output logic                    hreadyout_o,
  output logic                    hresp_o,
  output logic [31:0]             hrdata_o,
  // Clock sources as synchronous levels, index is the source code
  input  wire logic [8:0]         src_clk_i,
  // Power mode indications
  input  wire logic               idle_mode_i,
  input  wire logic               sleep_mode_i,
  // Reference clock output pin
  output logic                    ref_clock_out_pin_o,
  output logic                    ref_clock_out_pin_oe_o,
  output logic                    request_active_o
);
  import rcg_pkg::*;

  // ==========================================================
  // Declarations
  logic        dp_wr;
  logic        dp_rd;
  logic [7:0]  dp_addr;
  logic        addr_take;
  logic        wr_ctl;
  logic        wr_trim;
  logic        ctl_on;
  logic        stop_in_idle;
  logic        ctl_oe;
  logic        run_in_sleep;
  logic        active;
  rcg_sw_e     sw_state;
  rcg_cfg_s    pend;
  rcg_cfg_s    next_pend;
  rcg_cfg_s    act;
  logic        next_run;
  logic        sel_valid;
  logic        src_lvl;
  logic        src_q;
  logic        tick;
  logic        gen_clk;
  logic        bound;
  logic        apply;
  logic        sw_req;
  logic [31:0] next_rdata;

  // ==========================================================
  // Bus slave
  // Accept a transfer in its address phase
  assign addr_take = hsel_i && htrans_i[1] && hready_i;

  // Data phase tracking
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      dp_wr   <= 1'b0;
      dp_rd   <= 1'b0;
      dp_addr <= 8'h00;
    end else if (hready_i) begin
      dp_wr   <= addr_take && hwrite_i;
      dp_rd   <= addr_take && !hwrite_i;
      dp_addr <= haddr_i[7:0];
    end
  end

  // Reads take one wait state so that a prior write is visible
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      hreadyout_o <= 1'b1;
    end else if (hready_i) begin
      hreadyout_o <= !(addr_take && !hwrite_i);
    end else begin
      hreadyout_o <= 1'b1;
    end
  end

  // Response is always OKAY
  always_ff @(posedge core_clk_i) begin
    hresp_o <= 1'b0;
  end

  // Writes land at the end of the data phase
  assign wr_ctl  = dp_wr && hready_i && (dp_addr == `RCG_CTL_OFS);
  assign wr_trim = dp_wr && hready_i && (dp_addr == `RCG_TRIM_OFS);

  always_comb begin
    next_rdata = 32'h00000000;
    if (dp_addr == `RCG_CTL_OFS) begin
      next_rdata = {1'b0, pend.integer_divider, ctl_on, 1'b0, stop_in_idle, ctl_oe,
                    run_in_sleep, 1'b0, (sw_state == RCG_SW_WAIT), active, 4'h0,
                    pend.source_select};
    end else if (dp_addr == `RCG_TRIM_OFS) begin
      next_rdata = {pend.fractional_trim, 23'h000000};
    end
  end

  // Read data loaded in the wait state; unmapped reads give zero
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      hrdata_o <= 32'h00000000;
    end else if (dp_rd && !hreadyout_o) begin
      hrdata_o <= next_rdata;
    end
  end

  // ==========================================================
  // Control flags
  // flags reset to zero
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ctl_on       <= 1'b0;
      stop_in_idle <= 1'b0;
      ctl_oe       <= 1'b0;
      run_in_sleep <= 1'b0;
    end else if (wr_ctl) begin
      ctl_on       <= hwdata_i[`RCG_ON_BIT];
      stop_in_idle <= hwdata_i[`RCG_STOP_IN_IDLE_BIT];
      ctl_oe       <= hwdata_i[`RCG_OE_BIT];
      run_in_sleep <= hwdata_i[`RCG_RUN_IN_SLEEP_BIT];
    end
  end

  always_comb begin
    next_pend = pend;
    if (wr_ctl) begin
      next_pend.integer_divider = hwdata_i[`RCG_DIV_MSB:`RCG_DIV_LSB];
      next_pend.source_select   = hwdata_i[`RCG_SEL_MSB:`RCG_SEL_LSB];
    end
    if (wr_trim) begin
      next_pend.fractional_trim = hwdata_i[`RCG_TRIM_MSB:`RCG_TRIM_LSB];
    end
  end

  // Software view of divider, trim and source
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pend <= '0;
    end else begin
      pend <= next_pend;
    end
  end

  // ==========================================================
  // Divider switch handshake
  // request only counts while enabled
  assign sw_req = wr_ctl && hwdata_i[`RCG_DIVSW_BIT] && ctl_on;
  assign apply  = (sw_state == RCG_SW_WAIT) && bound;

  // hardware clears once applied, new set wins
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sw_state <= RCG_SW_IDLE;
    end else begin
      unique case (sw_state)
        RCG_SW_IDLE: begin
          if (sw_req) begin
            sw_state <= RCG_SW_WAIT;
          end
        end
        RCG_SW_WAIT: begin
          if (!ctl_on || (apply && !sw_req)) begin
            sw_state <= RCG_SW_IDLE;
          end
        end
      endcase
    end
  end

  // settings in use by the divider
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      act <= '0;
    end else if (!ctl_on) begin
      act <= next_pend;
    end else if (apply) begin
      act <= pend;
    end
  end

  // ==========================================================
  // Source selection and run control
  // pick the selected source level
  assign sel_valid = (act.source_select <= RCG_SRC_PIN);
  assign src_lvl   = sel_valid ? src_clk_i[act.source_select] : 1'b0;
  assign tick      = src_lvl && !src_q;

  // Previous source level for edge detection
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      src_q <= 1'b0;
    end else begin
      src_q <= src_lvl;
    end
  end

  always_comb begin
    next_run = ctl_on;
    if (idle_mode_i && stop_in_idle) begin
      next_run = 1'b0;
    end
    if (sleep_mode_i && !(run_in_sleep && (act.source_select > RCG_SRC_PB))) begin
      next_run = 1'b0;
    end
  end

  // request status follows the run condition
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      active <= 1'b0;
    end else begin
      active <= next_run;
    end
  end

  rcg_frac_div u_div (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .run_i      (active),
    .tick_i     (tick),
    .src_lvl_i  (src_lvl),
    .cfg_i      (act),
    .clk_o      (gen_clk),
    .bound_o    (bound)
  );

  // ==========================================================
  // Output pin
  // clock reaches pin only with output enable
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ref_clock_out_pin_o    <= 1'b0;
      ref_clock_out_pin_oe_o <= 1'b0;
      request_active_o       <= 1'b0;
    end else begin
      ref_clock_out_pin_o    <= active && ctl_oe && gen_clk;
      ref_clock_out_pin_oe_o <= ctl_oe;
      request_active_o       <= next_run;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_wait_hit;
    (sw_state == RCG_SW_WAIT) && bound && ctl_on && !sw_req;
  endsequence

  sequence s_cleared;
    (sw_state == RCG_SW_IDLE) ##0 (act == $past(pend));
  endsequence

  AST_OFF_NO_CLOCK: assert property (!ctl_on |=> ##1 !ref_clock_out_pin_o)
    else $error("pin toggled while generator disabled");
  AST_IDLE_HALT: assert property (idle_mode_i && stop_in_idle |=> !active)
    else $error("generator kept running in idle with stop set");
  AST_OE_GATES: assert property (!ctl_oe |=> !ref_clock_out_pin_o && !ref_clock_out_pin_oe_o)
    else $error("pin carried clock without output enable");
  AST_SLEEP_STOP: assert property (sleep_mode_i && !run_in_sleep |=> !active)
    else $error("generator ran in sleep without run-in-sleep");
  AST_SLEEP_SYSTEM_CLOCK: assert property (sleep_mode_i && act.source_select <= RCG_SRC_PB |=> !active)
    else $error("system or bus clock source ran in sleep");
  AST_PEND_HOLD: assert property (ctl_on && !apply |=> $stable(act))
    else $error("setting applied without switch request");
  AST_SWITCH_DONE: assert property (s_wait_hit |=> s_cleared)
    else $error("switch did not complete at boundary");
  AST_ACTIVE_CAUSE: assert property ($rose(active) |-> $past(ctl_on) && ctl_on)
    else $error("request status rose while disabled");
  AST_RESERVED_ZERO: assert property (hreadyout_o && $past(dp_rd) && !$past(hreadyout_o)
                                      |-> (hrdata_o & ~(`RCG_CTL_IMPL | `RCG_TRIM_IMPL)) == 32'h00000000)
    else $error("unimplemented bits read nonzero");
  AST_OFF_DIRECT: assert property (!ctl_on && wr_ctl
                                   |=> act.integer_divider == $past(hwdata_i[`RCG_DIV_MSB:`RCG_DIV_LSB]))
    else $error("disabled write did not apply directly");
  AST_RESET_CLEAR: assert property (disable iff (1'b0) srst_i |=> !ctl_on && !active && pend == '0 && act == '0)
    else $error("reset left state set");

endmodule

// >>> sim/rcg_ref_sink.sv
// Receiver model of the reference clock output: counts edges, times periods
`timescale 1ns/1ps
module rcg_ref_sink (
  input  wire logic core_clk_i,
  input  wire logic pin_i,
  input  wire logic pin_oe_i,
  output int        edges_o       = 0,
  output int        period_o      = 0,
  output int        prev_period_o = 0
);
  logic seen_q = 1'b0;
  int   cnt_q  = 0;

  // ==========================================================
  // Edge detection and period timing
  // A pin that is not driven counts as low
  always_ff @(posedge core_clk_i) begin
    seen_q <= pin_i & pin_oe_i;
    if (pin_i && pin_oe_i && !seen_q) begin
      edges_o       <= edges_o + 1;
      prev_period_o <= period_o;
      period_o      <= cnt_q;
      cnt_q         <= 1;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule

// >>> sim/test_reference_clock_generator.sv
// Self-checking testbench of the reference clock generator
`timescale 1ns/1ps
module test_reference_clock_generator;
  import rcg_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        srst_i     = 1'b1;
  logic        hsel       = 1'b0;
  logic [31:0] haddr      = 32'h0;
  logic [1:0]  htrans     = 2'h0;
  logic        hwrite     = 1'b0;
  logic [31:0] hwdata     = 32'h0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [8:0]  src_clk    = 9'h0;
  logic [2:0]  tick       = 3'h0;
  logic        idle       = 1'b0;
  logic        sleep      = 1'b0;
  logic        pin;
  logic        pin_oe;
  logic        req_act;
  int          edges;
  int          per;
  int          prev_per;
  int          err_count   = 0;
  int          comparisons = 0;
  logic [31:0] v;
  int          n;

  rcg_core u_rcg_core (.core_clk_i(core_clk_i), .srst_i(srst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata), .src_clk_i(src_clk),
    .idle_mode_i(idle), .sleep_mode_i(sleep), .ref_clock_out_pin_o(pin),
    .ref_clock_out_pin_oe_o(pin_oe), .request_active_o(req_act));

  rcg_ref_sink u_rcg_ref_sink (.core_clk_i(core_clk_i), .pin_i(pin), .pin_oe_i(pin_oe),
    .edges_o(edges), .period_o(per), .prev_period_o(prev_per));

  // ==========================================================
  // Clock and source levels: even codes period 4, odd codes period 8
  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    tick <= tick + 3'h1;
    for (int i = 0; i < 9; i++) begin
      src_clk[i] <= (i % 2 == 1) ? tick[2] : tick[1];
    end
  end

  // ==========================================================
  // Bus tasks and comparison
  task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= 1'b1;
    do @(posedge core_clk_i); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge core_clk_i); while (hreadyout !== 1'b1);
  endtask
  task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= 1'b0;
    do @(posedge core_clk_i); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0;
    do @(posedge core_clk_i); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Control word from divider, flag bits and source code
  function automatic logic [31:0] ctl(input int dv, input logic [31:0] f, input int s);
    return (32'(dv) << 16) | f | 32'(s);
  endfunction
  // Sum of two output periods once three new edges have passed
  task automatic meas(output int sum);
    int n0;
    n0 = edges;
    for (int k = 0; k < 600 && edges < n0 + 3; k++) @(posedge core_clk_i);
    sum = per + prev_per;
  endtask
  // Output edges within a window after settling
  task automatic edges_in(output int cnt);
    int n0;
    repeat (8) @(posedge core_clk_i);
    n0 = edges;
    repeat (96) @(posedge core_clk_i);
    cnt = edges - n0;
  endtask
  // Poll until the switch bit clears
  task automatic sw_wait();
    logic [31:0] r;
    bus_rd(32'h0, r);
    for (int k = 0; k < 40 && r[9] !== 1'b0; k++) bus_rd(32'h0, r);
    chk(32'(r[9]), 32'h0);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ==========================================================
  // Watchdog
  initial begin
    repeat (30000) @(posedge core_clk_i);
    err_count++;
    results();
  end

  // ==========================================================
  // Test sequence
  initial begin
    repeat (3) @(posedge core_clk_i);
    srst_i <= 1'b0;
    @(posedge core_clk_i);
    bus_rd(32'h0, v); chk(v, 32'h0);
    bus_rd(32'h4, v); chk(v, 32'h0);
    bus_rd(32'h8, v); chk(v, 32'h0);
    chk(32'(hresp), 32'h0);
    bus_wr(32'h0, 32'hFFFF7FFF);
    bus_rd(32'h0, v); chk(v, 32'h7FFF380F);
    bus_wr(32'h4, 32'hFFFFFFFF);
    bus_rd(32'h4, v); chk(v, 32'hFF800000);
    $display("test reset and access done");
    // Divider two applied directly while off
    bus_wr(32'h4, 32'h0);
    bus_wr(32'h0, ctl(2, 32'h1000, 2));
    bus_wr(32'h0, ctl(2, 32'h9000, 2));
    meas(n); chk(32'(n), 32'd32);
    chk(32'(req_act), 32'h1);
    chk(32'(pin_oe), 32'h1);
    bus_rd(32'h0, v); chk(32'(v[8]), 32'h1);
    $display("test direct divider done");
    // Held writes while on, then the switch handshake
    bus_wr(32'h4, 32'h80000000);
    bus_wr(32'h0, ctl(1, 32'h9000, 2));
    meas(n); chk(32'(n), 32'd32);
    bus_rd(32'h0, v); chk(32'(v[30:16]), 32'h1);
    bus_wr(32'h0, ctl(1, 32'h9200, 2));
    sw_wait();
    meas(n); chk(32'(n), 32'd24);
    $display("test switch and trim done");
    // Every valid source code, trim cleared; reserved codes never used
    bus_wr(32'h4, 32'h0);
    for (int s = 0; s < 9; s++) begin
      bus_wr(32'h0, ctl(1, 32'h9200, s));
      sw_wait();
      meas(n); chk(32'(n), (s % 2 == 1) ? 32'd32 : 32'd16);
    end
    $display("test source select done");
    bus_wr(32'h0, ctl(1, 32'h8000, 2));
    edges_in(n); chk(32'(n), 32'h0);
    chk(32'(pin_oe), 32'h0);
    idle <= 1'b1;
    bus_wr(32'h0, ctl(1, 32'hB000, 2));
    edges_in(n); chk(32'(n), 32'h0);
    chk(32'(req_act), 32'h0);
    bus_rd(32'h0, v); chk(32'(v[8]), 32'h0);
    bus_wr(32'h0, ctl(1, 32'h9000, 2));
    edges_in(n); chk(32'(n > 0), 32'h1);
    $display("test idle done");
    idle <= 1'b0;
    sleep <= 1'b1;
    edges_in(n); chk(32'(n), 32'h0);
    bus_wr(32'h0, ctl(1, 32'h9800, 2));
    edges_in(n); chk(32'(n > 0), 32'h1);
    // source changed only once the request is inactive
    bus_wr(32'h0, ctl(1, 32'h1800, 2));
    bus_wr(32'h0, ctl(1, 32'h1800, 0));
    bus_wr(32'h0, ctl(1, 32'h9800, 0));
    edges_in(n); chk(32'(n), 32'h0);
    $display("test sleep done");
    sleep <= 1'b0;
    bus_wr(32'h0, ctl(1, 32'h1000, 2));
    edges_in(n); chk(32'(n), 32'h0);
    chk(32'(req_act), 32'h0);
    $display("test disable done");
    results();
  end
endmodule
